//--- verilog/sfrt_pkg.sv
package sfrt_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CODE_FAULT_ACTION = 8'h63;
   localparam logic [7:0] CODE_TOFF_DELAY = 8'h64;
   localparam logic [7:0] CODE_TOFF_FALL = 8'h65;
   localparam logic [7:0] CODE_TOFF_WARN = 8'h66;

   // ----------------------------------------------------------------
   // fault action byte layout
   // ----------------------------------------------------------------
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int TIME_HI = 2;
   localparam int TIME_LO = 0;
   localparam logic [1:0] MODE_IGNORE = 2'h0;
   localparam logic [1:0] MODE_CONTINUE = 2'h1;
   localparam logic [1:0] MODE_BAD = 2'h2;
   localparam logic [1:0] MODE_DISABLE = 2'h3;
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FAULT_ACTION = 8'h00;
   localparam logic [15:0] RST_TOFF_DELAY = 16'h0000;
   localparam logic [15:0] RST_TOFF_FALL = 16'h0000;
   localparam logic [15:0] RST_TOFF_WARN = 16'h0000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int SYNC_BITS = 6;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       write;
      logic [7:0] code;
      logic [15:0] data;
   } sfrt_req_t;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_RUN = 3'b001,
      ST_CONT = 3'b010,
      ST_RETRY_WAIT = 3'b011,
      ST_LATCHED = 3'b100,
      ST_TOFF_DLY = 3'b101,
      ST_TOFF_FALL = 3'b110
   } sfrt_state_t;
endpackage : sfrt_pkg

//--- verilog/sfrt_core.sv
// Overview of operation
// - response mode comes from action bits 7:6
// - mode 00 ignores the start-up fault
// - mode 01 runs on, then retries if persisting
// - mode 11 disables at once, then retries
// - latched fault cleared by clear, reset, cycling, bias
// - retry code 000 stays off until cleared
// - codes 001-110 give one to six attempts
// - attempt starts spaced by the delay count
// - code 111 retries until off, bias, fault
// - time field n means 2**n units
// - unit length comes from time-unit configuration
// - unit shared with output voltage faults
// - wait turn-off delay before ramping down
// - ramp down over the fall time
// - warn if not below eighth within limit
// - zero start-up limit disables the fault
module sfrt_core
   import sfrt_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES
) (
   // clocks and reset
   input wire logic ref_clk_i,
   input wire logic link_clk_i,
   input wire logic reset_n_i,
   // command link, link clock domain
   input wire logic link_req_i,
   input wire logic link_write_i,
   input wire logic [7:0] link_code_i,
   input wire logic [15:0] link_wdata_i,
   output logic link_busy_o,
   output logic link_done_o,
   output logic [15:0] link_rdata_o,
   // power stage pins, asynchronous
   input wire logic startup_fault_i,
   input wire logic output_good_i,
   input wire logic control_on_i,
   input wire logic bias_ok_i,
   input wire logic other_fault_i,
   input wire logic vout_below_eighth_i,
   // same-clock configuration and status logic
   input wire logic [15:0] vout_unit_cycles_i,
   input wire logic startup_limit_zero_i,
   input wire logic fault_bit_clear_i,
   // power stage control and flags
   output logic output_enable_o,
   output logic ramp_down_o,
   output logic fault_latched_o,
   output logic toff_warn_o,
   output logic logic_fault_o,
   output logic [2:0] retry_count_o
);

   // ----------------------------------------------------------------
   // link domain: hold the request and toggle toward the core
   // ----------------------------------------------------------------
   logic link_rst_a, link_rst_n;
   sfrt_req_t link_hold;
   logic req_tgl, ack_s1, ack_s2;
   logic ack_tgl;
   logic [15:0] core_rdata;

   // reset released in step with the link clock
   always_ff @(posedge link_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_rst_a <= 1'b0;
         link_rst_n <= 1'b0;
      end else begin
         link_rst_a <= 1'b1;
         link_rst_n <= link_rst_a;
      end
   end

   // a request is taken only while idle; the held word stays still
   // until the core has answered, so it crosses without a gray code
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_hold <= '0;
         req_tgl <= 1'b0;
         link_busy_o <= 1'b0;
         link_done_o <= 1'b0;
         link_rdata_o <= 16'h0000;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         link_done_o <= 1'b0;
         if (link_busy_o && (ack_s2 == req_tgl)) begin
            link_busy_o <= 1'b0;
            link_done_o <= 1'b1;
            link_rdata_o <= core_rdata;
         end else if (!link_busy_o && link_req_i) begin
            link_hold <= '{write: link_write_i, code: link_code_i, data: link_wdata_i};
            req_tgl <= ~req_tgl;
            link_busy_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // core domain: synchronisers
   // ----------------------------------------------------------------
   logic req_s1, req_s2, req_s3;
   logic [SYNC_BITS-1:0] pin_s1, pin_s2;
   wire [SYNC_BITS-1:0] pin_raw = {vout_below_eighth_i, other_fault_i, bias_ok_i,
                                   control_on_i, output_good_i, startup_fault_i};

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   wire fault_now = pin_s2[0];
   wire good_now = pin_s2[1];
   wire ctrl_on = pin_s2[2];
   wire bias_ok = pin_s2[3];
   wire other_flt = pin_s2[4];
   wire below_now = pin_s2[5];
   wire req_new = req_s2 ^ req_s3;

   // ----------------------------------------------------------------
   // registers reached by command code
   // ----------------------------------------------------------------
   logic [7:0] fault_action;
   logic [15:0] toff_delay, toff_fall, toff_warn_lim;
   logic ctrl_q;

   wire is_wr = req_new && link_hold.write;
   wire wr_action = is_wr && (link_hold.code == CODE_FAULT_ACTION);
   wire action_bad = (link_hold.data[MODE_HI:MODE_LO] == MODE_BAD);
   wire clear_cmd = is_wr && (link_hold.code == CODE_CLEAR_FAULTS);
   wire code_known = (link_hold.code == CODE_FAULT_ACTION) || (link_hold.code == CODE_TOFF_DELAY)
                     || (link_hold.code == CODE_TOFF_FALL) || (link_hold.code == CODE_TOFF_WARN)
                     || (link_hold.code == CODE_CLEAR_FAULTS);
   wire cmd_error = req_new && (!code_known || (wr_action && action_bad));

   // register writes; a mode 10 action byte is dropped whole
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_action <= RST_FAULT_ACTION;
         toff_delay <= RST_TOFF_DELAY;
         toff_fall <= RST_TOFF_FALL;
         toff_warn_lim <= RST_TOFF_WARN;
      end else if (is_wr) begin
         if (link_hold.code == CODE_FAULT_ACTION && !action_bad) begin
            fault_action <= link_hold.data[7:0];
         end else if (link_hold.code == CODE_TOFF_DELAY) begin
            toff_delay <= link_hold.data;
         end else if (link_hold.code == CODE_TOFF_FALL) begin
            toff_fall <= link_hold.data;
         end else if (link_hold.code == CODE_TOFF_WARN) begin
            toff_warn_lim <= link_hold.data;
         end
      end
   end

   // read mux; the core answers every request in the cycle after it lands
   wire [15:0] rd_mux = (link_hold.code == CODE_FAULT_ACTION) ? {8'h00, fault_action} :
                        (link_hold.code == CODE_TOFF_DELAY) ? toff_delay :
                        (link_hold.code == CODE_TOFF_FALL) ? toff_fall :
                        (link_hold.code == CODE_TOFF_WARN) ? toff_warn_lim : 16'h0000;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         core_rdata <= 16'h0000;
         ack_tgl <= 1'b0;
      end else if (req_new) begin
         core_rdata <= rd_mux;
         ack_tgl <= ~ack_tgl;
      end
   end

   // ----------------------------------------------------------------
   // time bases: millisecond and fault time unit
   // ----------------------------------------------------------------
   logic [31:0] ms_pre;
   logic [15:0] unit_pre;
   wire ms_tick = (ms_pre == 32'(MS_CYC - 1));
   // a zero unit length is read as one cycle rather than stalling
   wire [15:0] unit_len = (vout_unit_cycles_i == 16'h0000) ? 16'h0001 : vout_unit_cycles_i;
   wire unit_tick = (unit_pre >= unit_len - 16'h0001);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ms_pre <= 32'h0000_0000;
         unit_pre <= 16'h0000;
      end else begin
         ms_pre <= ms_tick ? 32'h0000_0000 : ms_pre + 32'h0000_0001;
         unit_pre <= unit_tick ? 16'h0000 : unit_pre + 16'h0001;
      end
   end

   // linear word to whole milliseconds; negative values count as zero
   function automatic logic [23:0] lin_to_ms(input logic [15:0] v);
      logic signed [4:0] e;
      logic [23:0] r;
      e = v[15:11];
      r = {13'h0000, v[10:0]};
      if (v[10]) begin
         r = 24'h00_0000;
      end else if (e < 0) begin
         r = r >> 5'(-e);
      end else if (e > 5'sd13) begin
         r = 24'hFF_FFFF;
      end else begin
         r = r << e;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   sfrt_state_t state, next_state;
   logic [23:0] tmr, next_tmr;
   logic tmr_ms, next_tmr_ms;
   logic [2:0] tries, next_tries;

   wire [1:0] mode = fault_action[MODE_HI:MODE_LO];
   wire [2:0] retry_set = fault_action[RETRY_HI:RETRY_LO];
   wire [23:0] delay_units = 24'h00_0001 << fault_action[TIME_HI:TIME_LO];
   wire fault_evt = fault_now && !startup_limit_zero_i;
   wire tick = tmr_ms ? ms_tick : unit_tick;
   wire tmr_done = (tmr == 24'h00_0000);
   wire ctrl_fell = ctrl_q && !ctrl_on;
   wire hard_stop = !bias_ok || other_flt;
   // attempts left: forever, or fewer than programmed so far
   wire may_retry = (retry_set == RETRY_FOREVER) || (tries < retry_set);

   always_comb begin
      next_state = state;
      next_tmr = (tick && !tmr_done) ? tmr - 24'h00_0001 : tmr;
      next_tmr_ms = tmr_ms;
      next_tries = tries;
      case (state)
         ST_OFF: begin
            next_tries = 3'h0;
            if (ctrl_on && bias_ok && !other_flt) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN, ST_CONT: begin
            if (hard_stop) begin
               next_state = ST_OFF;
            end else if (!ctrl_on) begin
               next_state = ST_TOFF_DLY;
               next_tmr = lin_to_ms(toff_delay);
               next_tmr_ms = 1'b1;
            end else if (state == ST_RUN) begin
               if (good_now && !fault_evt) begin
                  next_tries = 3'h0;
               end
               if (fault_evt && mode == MODE_CONTINUE) begin
                  next_state = ST_CONT;
                  next_tmr = delay_units;
                  next_tmr_ms = 1'b0;
               end else if (fault_evt && mode == MODE_DISABLE) begin
                  next_state = (retry_set == RETRY_NONE || !may_retry) ? ST_LATCHED : ST_RETRY_WAIT;
                  next_tmr = delay_units;
                  next_tmr_ms = 1'b0;
               end
               // mode 00 stays regulating through the fault
            end else if (!fault_evt) begin
               next_state = ST_RUN;
            end else if (tmr_done) begin
               next_state = (retry_set == RETRY_NONE || !may_retry) ? ST_LATCHED : ST_RETRY_WAIT;
               next_tmr = delay_units;
            end
         end
         ST_RETRY_WAIT: begin
            if (hard_stop || !ctrl_on) begin
               next_state = ST_OFF;
            end else if (tmr_done) begin
               next_state = ST_RUN;
               if (tries != RETRY_FOREVER) begin
                  next_tries = tries + 3'h1;
               end
            end
         end
         ST_LATCHED: begin
            // output stays disabled until a clearing event
            if (clear_cmd || fault_bit_clear_i || ctrl_fell || !bias_ok) begin
               next_state = ST_OFF;
            end
         end
         ST_TOFF_DLY: begin
            if (tmr_done) begin
               next_state = ST_TOFF_FALL;
               next_tmr = lin_to_ms(toff_fall);
               next_tmr_ms = 1'b1;
            end
         end
         ST_TOFF_FALL: begin
            if (tmr_done) begin
               next_state = ST_OFF;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_OFF;
         tmr <= 24'h00_0000;
         tmr_ms <= 1'b0;
         tries <= 3'h0;
         ctrl_q <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         tmr_ms <= next_tmr_ms;
         tries <= next_tries;
         ctrl_q <= ctrl_on;
      end
   end

   // ----------------------------------------------------------------
   // flags: a new event wins over a clear in the same cycle
   // ----------------------------------------------------------------
   logic warn_run;
   logic [23:0] warn_cnt;
   wire latch_set = (next_state == ST_LATCHED || next_state == ST_RETRY_WAIT)
                    && (state == ST_RUN || state == ST_CONT);
   wire fault_clr = clear_cmd || fault_bit_clear_i || ctrl_fell || !bias_ok;
   wire disable_evt = (state == ST_RUN || state == ST_CONT) && next_state == ST_TOFF_DLY;
   wire warn_hit = warn_run && !below_now && (warn_cnt >= lin_to_ms(toff_warn_lim));

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_latched_o <= 1'b0;
         logic_fault_o <= 1'b0;
         toff_warn_o <= 1'b0;
      end else begin
         fault_latched_o <= latch_set || (fault_latched_o && !fault_clr);
         logic_fault_o <= cmd_error || (logic_fault_o && !clear_cmd);
         toff_warn_o <= warn_hit || (toff_warn_o && !clear_cmd);
      end
   end

   // warning timer runs from the disable event until the output is low or the warning is raised
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         warn_run <= 1'b0;
         warn_cnt <= 24'h00_0000;
      end else if (disable_evt) begin
         warn_run <= 1'b1;
         warn_cnt <= 24'h00_0000;
      end else if (warn_run) begin
         warn_run <= !(below_now || warn_hit);
         warn_cnt <= (ms_tick && warn_cnt != 24'hFF_FFFF) ? warn_cnt + 24'h00_0001 : warn_cnt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         output_enable_o <= 1'b0;
         ramp_down_o <= 1'b0;
         retry_count_o <= 3'h0;
      end else begin
         // regulation holds through the turn-off delay, ramps in the fall
         output_enable_o <= (next_state == ST_RUN || next_state == ST_CONT
                             || next_state == ST_TOFF_DLY);
         ramp_down_o <= (next_state == ST_TOFF_FALL);
         retry_count_o <= next_tries;
      end
   end

endmodule // sfrt_core

//--- testbench/sfrt_core_checker.sv
module sfrt_chk
   import sfrt_pkg::*;
(
   // clocks and reset
   input wire logic ref_clk_i,
   input wire logic link_clk_i,
   input wire logic reset_n_i,
   // link answers
   input wire logic link_busy_o,
   input wire logic link_done_o,
   // power stage pins
   input wire logic startup_fault_i,
   input wire logic control_on_i,
   input wire logic bias_ok_i,
   input wire logic other_fault_i,
   input wire logic startup_limit_zero_i,
   // sequencer outputs
   input wire logic output_enable_o,
   input wire logic fault_latched_o,
   input wire logic [2:0] retry_count_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // link handshake and sequencer relations
   // ----------------------------------------------------------------
   property p_done_pulse;
      @(posedge link_clk_i) disable iff (!reset_n_i) link_done_o |=> !link_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
   // a taken request is always answered
   property p_answer;
      @(posedge link_clk_i) disable iff (!reset_n_i) $rose(link_busy_o) |-> ##[2:16] link_done_o;
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   property p_bias_off;
      @(posedge ref_clk_i) disable iff (!reset_n_i) $fell(bias_ok_i) |-> ##[1:6] !output_enable_o;
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("output kept after bias loss");
   property p_other_off;
      @(posedge ref_clk_i) disable iff (!reset_n_i) $rose(other_fault_i) |-> ##[1:6] !output_enable_o;
   endproperty
   a_other_off: assert property (p_other_off) else $error("output kept after other fault");
   // zero limit: output never drops while pins stay good
   property p_zero_limit;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         (startup_limit_zero_i && bias_ok_i && control_on_i && !other_fault_i && output_enable_o) [*6]
         |=> output_enable_o;
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("fault acted on with zero limit");
   property p_latch_cause;
      @(posedge ref_clk_i) disable iff (!reset_n_i) $rose(fault_latched_o) |-> $past(startup_fault_i, 3);
   endproperty
   a_latch_cause: assert property (p_latch_cause) else $error("latched without fault");
   property p_enable_cause;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         $rose(output_enable_o) |-> $past(control_on_i, 3) && $past(bias_ok_i, 3) && !$past(other_fault_i, 3);
   endproperty
   a_enable_cause: assert property (p_enable_cause) else $error("output on while forced off");
   property p_retry_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
         ($changed(retry_count_o) && retry_count_o != 3'h0) |-> retry_count_o == $past(retry_count_o) + 3'h1;
   endproperty
   a_retry_step: assert property (p_retry_step) else $error("retry count skipped");
endmodule // sfrt_chk

bind sfrt_core sfrt_chk chk_u (.*);

//--- testbench/sfrt_host_model.sv
module sfrt_host
   import sfrt_pkg::*;
(
   // link drive
   output logic link_clk_o,
   output logic link_req_o,
   output logic link_write_o,
   output logic [7:0] link_code_o,
   output logic [15:0] link_wdata_o,
   // device answers
   input wire logic link_busy_i,
   input wire logic link_done_i,
   input wire logic [15:0] link_rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // host side of the command link
   // ----------------------------------------------------------------
   initial {link_clk_o, link_req_o, link_write_o, link_code_o, link_wdata_o} = '0;
   // clock only runs inside frames and idle calls, lines change after the falling edge
   task automatic tick();
      #80;
      link_clk_o = 1'b1;
      #80;
      link_clk_o = 1'b0;
   endtask
   task automatic idle(input int cnt);
      repeat (cnt) tick();
   endtask
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] d, output logic [15:0] q,
                       output logic ok);
      ok = 1'b0;
      q = '0;
      if (link_busy_i !== 1'b0) return;
      link_req_o = 1'b1;
      link_write_o = wr;
      link_code_o = code;
      link_wdata_o = d;
      tick();
      // released lines show the inverse, never a stale value
      link_req_o = 1'b0;
      link_write_o = ~wr;
      link_code_o = ~code;
      link_wdata_o = ~d;
      for (int i = 0; i < 40 && ok !== 1'b1; i++) begin
         tick();
         if (link_done_i === 1'b1) begin
            ok = 1'b1;
            q = link_rdata_i;
         end
      end
      tick();
   endtask
endmodule // sfrt_host

//--- testbench/sfrt_core_tb.sv
module sfrt_core_tb
   import sfrt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // stimulus, instances and tasks
   // ----------------------------------------------------------------
   localparam int MSC = 40;
   localparam int UNIT = 20;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, fault = 1'b0, good = 1'b1, ctrl = 1'b0, bias = 1'b1;
   logic oth = 1'b0, below = 1'b0, lim0 = 1'b0, bitclr = 1'b0;
   logic [15:0] unit = 16'h0014;
   logic lclk, lreq, lwr, busy, done, en, ramp, latched, warn, lfault;
   logic [7:0] lcode;
   logic [15:0] lwd, lrd;
   logic [2:0] tries;
   logic [15:0] tv [4] = '{16'h00F9, 16'h0002, 16'h0003, 16'h0004};
   int errors = 0, checks = 0, n, r, g, k;

   always #12.5 ref_clk_i = ~ref_clk_i;

   sfrt_core #(.MS_CYC(MSC)) dut_u (
      .ref_clk_i(ref_clk_i), .link_clk_i(lclk), .reset_n_i(reset_n_i), .link_req_i(lreq), .link_write_i(lwr),
      .link_code_i(lcode), .link_wdata_i(lwd), .link_busy_o(busy), .link_done_o(done), .link_rdata_o(lrd),
      .startup_fault_i(fault), .output_good_i(good), .control_on_i(ctrl), .bias_ok_i(bias), .other_fault_i(oth),
      .vout_below_eighth_i(below), .vout_unit_cycles_i(unit), .startup_limit_zero_i(lim0),
      .fault_bit_clear_i(bitclr), .output_enable_o(en), .ramp_down_o(ramp), .fault_latched_o(latched),
      .toff_warn_o(warn), .logic_fault_o(lfault), .retry_count_o(tries)
   );
   sfrt_host host_u (
      .link_clk_o(lclk), .link_req_o(lreq), .link_write_o(lwr), .link_code_o(lcode), .link_wdata_o(lwd),
      .link_busy_i(busy), .link_done_i(done), .link_rdata_i(lrd)
   );

   task automatic end_sim();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge ref_clk_i);
   endtask
   // transfers end on a falling edge, off the sampling edge
   task automatic xf(input logic w, input logic [7:0] code, input logic [15:0] d, output logic [15:0] q);
      logic ok;
      host_u.xfer(w, code, d, q, ok);
      chk("link answer", 16'(ok), 16'h0001);
      if (ok !== 1'b1) end_sim();
      @(negedge ref_clk_i);
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] d);
      logic [15:0] q;
      xf(1'b1, code, d, q);
   endtask
   task automatic rd(input logic [7:0] code, input logic [15:0] exp, input string name);
      logic [15:0] q;
      xf(1'b0, code, 16'h0000, q);
      chk(name, q, exp);
   endtask
   // bounded wait on enable or ramp, c returns the cycles taken
   task automatic wt(input logic rmp, input logic v, output int c);
      c = 0;
      while ((rmp ? ramp : en) !== v) begin
         @(negedge ref_clk_i);
         c++;
         if (c > 3000) begin
            errors++;
            $display("Error wait expected %b seen timeout", v);
            end_sim();
         end
      end
   endtask
   // counts restarts in a window, gg is the cycle of the first one
   task automatic cnt(input int w, output int rr, output int gg);
      logic p;
      rr = 0;
      gg = 0;
      for (int c = 1; c <= w; c++) begin
         p = en;
         @(negedge ref_clk_i);
         if (p === 1'b0 && en === 1'b1) begin
            rr++;
            if (rr == 1) gg = c;
         end
      end
   endtask
   task automatic rst();
      reset_n_i = 1'b0;
      cyc(2);
      reset_n_i = 1'b1;
      host_u.idle(3);
   endtask

   initial begin
      rst();
      for (int i = 0; i < 4; i++) begin
         rd(CODE_FAULT_ACTION + 8'(i), 16'h0000, "reset value");
         wr(CODE_FAULT_ACTION + 8'(i), tv[i]);
         rd(CODE_FAULT_ACTION + 8'(i), tv[i], "readback");
      end
      wr(CODE_FAULT_ACTION, 16'h0080);
      rd(CODE_FAULT_ACTION, 16'h00F9, "bad mode kept");
      chk("logic fault", 16'(lfault), 16'h0001);
      wr(CODE_CLEAR_FAULTS, 16'h0000);
      chk("logic fault clear", 16'(lfault), 16'h0000);
      rd(8'h70, 16'h0000, "unmapped read");
      chk("unmapped fault", 16'(lfault), 16'h0001);
      wr(CODE_CLEAR_FAULTS, 16'h0000);
      $display("test registers done");
      ctrl = 1'b1;
      wt(1'b0, 1'b1, n);
      wr(CODE_FAULT_ACTION, 16'h0000);
      fault = 1'b1;
      cyc(200);
      chk("ignore mode", 16'(en), 16'h0001);
      lim0 = 1'b1;
      cyc(5);
      wr(CODE_FAULT_ACTION, 16'h00C0);
      cyc(200);
      chk("zero limit", 16'(en), 16'h0001);
      fault = 1'b0;
      cyc(5);
      lim0 = 1'b0;
      $display("test ignore done");
      // retry codes 0 to 6, time field cycling through 0 to 3
      for (k = 0; k < 7; k++) begin
         wr(CODE_FAULT_ACTION, {8'h00, 2'b11, 3'(k), 3'(k % 4)});
         fault = 1'b1;
         wt(1'b0, 1'b0, n);
         chk("disable delay", 16'(n <= 6), 16'h0001);
         cnt(700, r, g);
         chk("attempts", 16'(r), 16'(k));
         chk("tries", 16'(tries), 16'(k));
         chk("spacing", 16'(k == 0 || (g >= (UNIT << (k % 4)) - UNIT && g <= (UNIT << (k % 4)) + 8)), 16'h0001);
         fault = 1'b0;
         wr(CODE_CLEAR_FAULTS, 16'h0000);
         wt(1'b0, 1'b1, n);
         chk("latched clear", 16'(latched), 16'h0000);
      end
      wr(CODE_FAULT_ACTION, 16'h00F8);
      fault = 1'b1;
      cnt(400, r, g);
      chk("endless", 16'(r >= 8), 16'h0001);
      oth = 1'b1;
      cyc(8);
      cnt(200, r, g);
      chk("no restart", 16'(r), 16'h0000);
      fault = 1'b0;
      cyc(5);
      oth = 1'b0;
      wt(1'b0, 1'b1, n);
      wr(CODE_FAULT_ACTION, 16'h004A);
      fault = 1'b1;
      cyc(55);
      chk("keeps running", 16'(en), 16'h0001);
      wt(1'b0, 1'b0, n);
      chk("continue time", 16'(n <= 40), 16'h0001);
      fault = 1'b0;
      wr(CODE_CLEAR_FAULTS, 16'h0000);
      wt(1'b0, 1'b1, n);
      $display("test retry done");
      wr(CODE_FAULT_ACTION, 16'h00C0);
      chk("retry reset", 16'(tries), 16'h0000);
      for (k = 0; k < 3; k++) begin
         fault = 1'b1;
         wt(1'b0, 1'b0, n);
         fault = 1'b0;
         cyc(300);
         chk("stays off", 16'(en), 16'h0000);
         case (k)
            0: bitclr = 1'b1;
            1: ctrl = 1'b0;
            default: bias = 1'b0;
         endcase
         cyc(k == 0 ? 1 : 10);
         bitclr = 1'b0;
         ctrl = 1'b1;
         bias = 1'b1;
         wt(1'b0, 1'b1, n);
      end
      $display("test clearing done");
      for (k = 0; k < 2; k++) begin
         below = k[0];
         cyc(5);
         ctrl = 1'b0;
         wt(1'b1, 1'b1, n);
         chk("off delay", 16'(n >= MSC && n <= 2 * MSC + 8), 16'h0001);
         wt(1'b1, 1'b0, n);
         chk("fall time", 16'(n >= 2 * MSC && n <= 3 * MSC + 8), 16'h0001);
         cyc(60);
         chk("warning", 16'(warn), 16'(!k[0]));
         wr(CODE_CLEAR_FAULTS, 16'h0000);
         chk("warning clear", 16'(warn), 16'h0000);
         ctrl = 1'b1;
         wt(1'b0, 1'b1, n);
      end
      $display("test turn off done");
      rst();
      rd(CODE_FAULT_ACTION, 16'h0000, "reset again");
      $display("test reset done");
      end_sim();
   end
endmodule // sfrt_core_tb
